//--- hw/mcs_params.svh
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

`define MCS_ADDR_PLL_SRC_UPDATE 32'h40048044
`define MCS_ADDR_MAIN_SRC_SELECT 32'h40048070
`define MCS_ADDR_MAIN_SRC_UPDATE 32'h40048074
`define MCS_ADDR_SYS_CLK_DIV 32'h40048078
`define MCS_ADDR_BLOCK_GATES 32'h40048080

`define MCS_RST_UPDATE 1'h0
`define MCS_RST_MAIN_SEL 2'h0
`define MCS_RST_PLL_SRC 2'h0
`define MCS_RST_SYS_DIV 8'h01
`define MCS_RST_GATES 6'h1F
`define MCS_GATE_ALWAYS_ON 6'h01

`define MCS_UPDATE_BIT 0
`define MCS_SEL_MSB 1
`define MCS_DIV_MSB 7
`define MCS_GATE_MSB 5

`define MCS_PLL_SRC_RESERVED 2'h3
`define MCS_RESP_OKAY 2'h0
`define MCS_RESP_SLVERR 2'h2

`endif

//--- hw/mcs_pkg.sv
`default_nettype none
package mcs_pkg;

	typedef enum logic [1:0] {
		MCS_MAIN_IRC,
		MCS_MAIN_PLL_IN,
		MCS_MAIN_WDT,
		MCS_MAIN_PLL_OUT
	} mcs_main_src_t;

	typedef enum logic [1:0] {
		MCS_PLL_IRC,
		MCS_PLL_SYS_OSC,
		MCS_PLL_WDT,
		MCS_PLL_RESERVED
	} mcs_pll_src_t;

	// One clock tick per source, bit order matches the main select codes.
	typedef struct packed {
		logic pll_out;
		logic wdt_osc;
		logic pll_in;
		logic internal_rc_osc;
	} mcs_src_ticks_t;

	// Gated system clock ticks, one per consumer, low bit is the core group.
	typedef struct packed {
		logic i2c;
		logic flash_array_gate;
		logic flash_regif_gate;
		logic ram;
		logic rom;
		logic core;
	} mcs_gated_t;

endpackage : mcs_pkg
`default_nettype wire

//--- hw/mcs_sys_divider.sv
`timescale 1ns/1ns
`default_nettype none
`include "mcs_params.svh"

module mcs_sys_divider
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic main_tick,
	input wire logic [7:0] divide_by,
	output logic sys_tick
);
	import mcs_pkg::*;

	logic [7:0] count_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_reg <= 8'h00;
			sys_tick <= 1'b0;
		end
		else if (divide_by == 8'h00)
		begin
			count_reg <= 8'h00;
			sys_tick <= 1'b0;
		end
		else if (main_tick)
		begin
			// A shrunk divisor restarts the count so no period runs long.
			if (count_reg >= divide_by - 8'h01)
			begin
				count_reg <= 8'h00;
				sys_tick <= 1'b1;
			end
			else
			begin
				count_reg <= count_reg + 8'h01;
				sys_tick <= 1'b0;
			end
		end
		else
		begin
			sys_tick <= 1'b0;
		end
	end

endmodule : mcs_sys_divider
`default_nettype wire

//--- hw/mcs_top.sv
// Overview of operation
// - PLL source update register is bit 0, reset 0; a 0 to 1 write applies a non-reserved new source.
// - PLL source codes: 00 internal RC, 01 system osc, 10 watchdog, 11 reserved.
// - Main source field bits 1:0, reset 0; 00 RC,01 PLL in,10 WDT,11 PLL out.
// - New main source applies only on a low-to-high update bit transition.
// - Main update register is one bit at bit 0, reset 0.
// - The selected main clock feeds core, peripherals and memories.
// - Divider value zero stops the system clock entirely.
// - Divider bits 7:0 divide main clock by N, reset value one.
// - Gate bit 0 feeds the core group, read-only, always enabled.
// - Gate bit 1 enables the ROM clock, reset one.
// - Gate bit 2 enables the RAM clock, reset one.
// - Gate bit 3 enables the flash register interface clock, reset one.
// - Gate bit 4 enables the flash array clock, reset one.
// - Gate bit 5 enables the I2C clock, reset zero.
`timescale 1ns/1ns
`default_nettype none
`include "mcs_params.svh"

module mcs_top
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire mcs_pkg::mcs_src_ticks_t src_ticks,
	input wire mcs_pkg::mcs_pll_src_t pll_src_select,
	output mcs_pkg::mcs_pll_src_t pll_src_active,
	output mcs_pkg::mcs_main_src_t main_src_active,
	output logic main_tick,
	output mcs_pkg::mcs_gated_t gated_ticks
);
	import mcs_pkg::*;

	typedef enum {
		WR_IDLE,
		WR_RESP
	} mcs_wr_state_t;

	mcs_wr_state_t wr_state_reg;
	logic [31:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic pll_update_reg;
	logic main_update_reg;
	mcs_main_src_t main_sel_reg;
	mcs_main_src_t main_pending_reg;
	logic main_switch_pending_reg;
	logic [7:0] sys_div_reg;
	logic [5:0] gates_reg;
	logic sys_tick;
	logic do_write;
	logic byte0_wr;

	function automatic logic addr_mapped(input logic [31:0] a);
		addr_mapped = (a == `MCS_ADDR_PLL_SRC_UPDATE) ||
			(a == `MCS_ADDR_MAIN_SRC_SELECT) ||
			(a == `MCS_ADDR_MAIN_SRC_UPDATE) ||
			(a == `MCS_ADDR_SYS_CLK_DIV) ||
			(a == `MCS_ADDR_BLOCK_GATES);
	endfunction : addr_mapped

	function automatic logic pick_tick(input mcs_src_ticks_t t,
		input mcs_main_src_t s);
		pick_tick = t[s];
	endfunction : pick_tick

	assign do_write = aw_have_reg && w_have_reg && (wr_state_reg == WR_IDLE);
	assign byte0_wr = do_write && wstrb_reg[0];

	// Write address and data are taken independently, in either order.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg <= 1'b0;
			awaddr_reg <= 32'h00000000;
			s_axi_awready <= 1'b1;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_reg <= 1'b1;
			awaddr_reg <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			aw_have_reg <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_have_reg <= 1'b0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_wready <= 1'b1;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_reg <= 1'b1;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			w_have_reg <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state_reg <= WR_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MCS_RESP_OKAY;
		end
		else
		begin
			case (wr_state_reg)
				WR_IDLE:
				begin
					if (do_write)
					begin
						wr_state_reg <= WR_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= addr_mapped(awaddr_reg) ?
							`MCS_RESP_OKAY : `MCS_RESP_SLVERR;
					end
				end
				WR_RESP:
				begin
					if (s_axi_bready)
					begin
						wr_state_reg <= WR_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
				default:
				begin
					wr_state_reg <= WR_IDLE;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	// All fields live in byte lane 0; upper lanes are reserved.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pll_update_reg <= `MCS_RST_UPDATE;
			main_update_reg <= `MCS_RST_UPDATE;
			main_sel_reg <= mcs_main_src_t'(`MCS_RST_MAIN_SEL);
			sys_div_reg <= `MCS_RST_SYS_DIV;
			gates_reg <= `MCS_RST_GATES;
		end
		else if (byte0_wr)
		begin
			case (awaddr_reg)
				`MCS_ADDR_PLL_SRC_UPDATE:
					pll_update_reg <= wdata_reg[`MCS_UPDATE_BIT];
				`MCS_ADDR_MAIN_SRC_SELECT:
					main_sel_reg <= mcs_main_src_t'(wdata_reg[`MCS_SEL_MSB:0]);
				`MCS_ADDR_MAIN_SRC_UPDATE:
					main_update_reg <= wdata_reg[`MCS_UPDATE_BIT];
				`MCS_ADDR_SYS_CLK_DIV:
					sys_div_reg <= wdata_reg[`MCS_DIV_MSB:0];
				`MCS_ADDR_BLOCK_GATES:
					gates_reg <= wdata_reg[`MCS_GATE_MSB:0] | `MCS_GATE_ALWAYS_ON;
				default:
					gates_reg <= gates_reg;
			endcase
		end
	end

	// PLL source is committed only on a 0 to 1 write of the update bit.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pll_src_active <= mcs_pll_src_t'(`MCS_RST_PLL_SRC);
		end
		else if (byte0_wr && awaddr_reg == `MCS_ADDR_PLL_SRC_UPDATE &&
			!pll_update_reg && wdata_reg[`MCS_UPDATE_BIT] &&
			pll_src_select != mcs_pll_src_t'(`MCS_PLL_SRC_RESERVED))
		begin
			pll_src_active <= pll_src_select;
		end
	end

	// The switch waits for a cycle with no tick on either source, so the
	// outgoing and incoming clocks never clip a pulse.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			main_src_active <= mcs_main_src_t'(`MCS_RST_MAIN_SEL);
			main_pending_reg <= mcs_main_src_t'(`MCS_RST_MAIN_SEL);
			main_switch_pending_reg <= 1'b0;
		end
		else if (byte0_wr && awaddr_reg == `MCS_ADDR_MAIN_SRC_UPDATE &&
			!main_update_reg && wdata_reg[`MCS_UPDATE_BIT])
		begin
			main_pending_reg <= main_sel_reg;
			main_switch_pending_reg <= 1'b1;
		end
		else if (main_switch_pending_reg &&
			!pick_tick(src_ticks, main_src_active) &&
			!pick_tick(src_ticks, main_pending_reg))
		begin
			main_src_active <= main_pending_reg;
			main_switch_pending_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			main_tick <= 1'b0;
		end
		else
		begin
			main_tick <= !main_switch_pending_reg &&
				pick_tick(src_ticks, main_src_active);
		end
	end

	mcs_sys_divider u_sys_divider
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.main_tick(main_tick),
		.divide_by(sys_div_reg),
		.sys_tick(sys_tick)
	);

	// Gates act on whole ticks, so a toggled enable cannot cut a pulse.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gated_ticks <= '0;
		end
		else
		begin
			gated_ticks <= {6{sys_tick}} & (gates_reg | `MCS_GATE_ALWAYS_ON);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `MCS_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= addr_mapped(s_axi_araddr) ?
				`MCS_RESP_OKAY : `MCS_RESP_SLVERR;
			case (s_axi_araddr)
				`MCS_ADDR_PLL_SRC_UPDATE:
					s_axi_rdata <= {31'h00000000, pll_update_reg};
				`MCS_ADDR_MAIN_SRC_SELECT:
					s_axi_rdata <= {30'h00000000, main_sel_reg};
				`MCS_ADDR_MAIN_SRC_UPDATE:
					s_axi_rdata <= {31'h00000000, main_update_reg};
				`MCS_ADDR_SYS_CLK_DIV:
					s_axi_rdata <= {24'h000000, sys_div_reg};
				`MCS_ADDR_BLOCK_GATES:
					s_axi_rdata <= {26'h0000000, gates_reg};
				default:
					s_axi_rdata <= 32'h00000000;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : mcs_top
`default_nettype wire

//--- verif/mcs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module mcs_checker
	import mcs_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire mcs_src_ticks_t src_ticks,
	input wire mcs_pll_src_t pll_src_active,
	input wire mcs_main_src_t main_src_active,
	input wire logic main_tick,
	input wire mcs_gated_t gated_ticks
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_core_gate_on: assert property (gated_ticks != '0 |-> gated_ticks.core)
		else $error("Gated tick without core tick.");
	a_tick_has_src: assert property (main_tick |-> $past(src_ticks) != '0)
		else $error("Main tick without a source tick.");
	a_sys_after_main: assert property (gated_ticks != '0 |-> $past(main_tick, 2))
		else $error("Gated tick not two cycles after main tick.");
	a_pll_legal: assert property (pll_src_active != MCS_PLL_RESERVED)
		else $error("Reserved PLL source committed.");
	a_switch_quiet: assert property ($changed(main_src_active)
		|-> !main_tick)
		else $error("Main tick in the cycle of a source switch.");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped early.");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped early.");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("Write response late.");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|-> ##[1:2] s_axi_rvalid)
		else $error("Read response late.");
	a_write_busy: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("Write channels ready during response.");
	c_main_tick: cover property (main_tick);
	c_i2c_tick: cover property (gated_ticks.i2c);
	c_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : mcs_checker
`default_nettype wire

//--- verif/main_clock_select_gate_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module main_clock_select_gate_tb_top;
	import mcs_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, main_tick;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	mcs_src_ticks_t src_ticks = 4'h0;
	mcs_pll_src_t pll_src_select = MCS_PLL_IRC;
	mcs_pll_src_t pll_src_active;
	mcs_main_src_t main_src_active;
	mcs_gated_t gated_ticks;
	logic [31:0] rng = 32'h15D15;
	logic [31:0] adr [5] = '{32'h40048044, 32'h40048070, 32'h40048074,
		32'h40048078, 32'h40048080};
	logic [31:0] rst [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1F};
	int err_total = 0, num_checks = 0;
	int i, k, s, n, mc, bad, nd, pe;
	int gc [6];
	int divs [4] = '{0, 1, 3, 255};
	logic [5:0] g;
	logic pre;
	mcs_top i_dut
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.src_ticks(src_ticks),
		.pll_src_select(pll_src_select),
		.pll_src_active(pll_src_active),
		.main_src_active(main_src_active),
		.main_tick(main_tick),
		.gated_ticks(gated_ticks)
	);
	always #2 aclk = ~aclk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	// Random source ticks keep switches and dividers busy at odd phases.
	always @(posedge aclk)
	begin
		rng <= xs(rng);
		src_ticks <= rng[3:0];
	end
	task automatic give_verdict();
		if (err_total == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		num_checks++;
		if (v !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, v);
			err_total++;
		end
	endtask : chk
	// Response readies rise at random so stalled answers are exercised.
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [1:0] er);
		int t;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_arvalid <= !w;
		for (t = 0; t < 80; t++)
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) break;
			s_axi_bready <= s_axi_bready | rng[4];
			s_axi_rready <= s_axi_rready | rng[5];
		end
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
		if (!w) chk("rdata", e, s_axi_rdata);
		chk("resp", {30'h0, er}, {30'h0, w ? s_axi_bresp : s_axi_rresp});
		if (t == 80)
		begin
			err_total++;
			give_verdict();
		end
	endtask : bus
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		for (i = 0; i < 5; i++)
			bus(0, adr[i], 0, rst[i], 2'h0);
		bus(0, 32'h4004807C, 0, 0, 2'h2);
		bus(1, 32'h4004807C, 32'hFFFFFFFF, 0, 2'h2);
		bus(1, adr[2], 1, 0, 2'h0);
		bus(1, adr[1], 32'hFFFFFFFE, 0, 2'h0);
		bus(0, adr[1], 0, 32'h2, 2'h0);
		bus(1, adr[4], 32'hFFFFFF00, 0, 2'h0);
		bus(0, adr[4], 0, 32'h1, 2'h0);
		s_axi_wstrb <= 4'hE;
		bus(1, adr[3], 32'h0, 0, 2'h0);
		s_axi_wstrb <= 4'hF;
		bus(0, adr[3], 0, 32'h1, 2'h0);
		repeat (8) @(posedge aclk);
		chk("sel_only", 0, main_src_active);
		for (k = 0; k < 4; k++)
		begin
			s = (k + 1) & 3;
			bus(1, adr[1], s, 0, 2'h0);
			bus(1, adr[2], 1, 0, 2'h0);
			repeat (8) @(posedge aclk);
			chk("hold", k, main_src_active);
			bus(1, adr[2], 0, 0, 2'h0);
			bus(1, adr[2], 1, 0, 2'h0);
			for (n = 0; n < 100 && main_src_active !== s; n++) @(posedge aclk);
			chk("switch", s, main_src_active);
		end
		pe = 0;
		for (k = 0; k < 4; k++)
		begin
			s = (k + 2) & 3;
			@(posedge aclk);
			pll_src_select <= mcs_pll_src_t'(s);
			bus(1, adr[0], 0, 0, 2'h0);
			bus(1, adr[0], 1, 0, 2'h0);
			repeat (4) @(posedge aclk);
			if (s != 3) pe = s;
			chk("pll", pe, pll_src_active);
		end
		for (k = 0; k < 4; k++)
		begin
			nd = divs[k];
			g = rng[5:0] | {k[0], 5'h0};
			bus(1, adr[3], {rng[31:8], nd[7:0]}, 0, 2'h0);
			bus(0, adr[3], 0, nd, 2'h0);
			bus(1, adr[4], g, 0, 2'h0);
			repeat (6) @(posedge aclk);
			mc = 0;
			bad = 0;
			gc = '{default: 0};
			repeat (300)
			begin
				@(posedge aclk);
				pre = src_ticks[0];
				#1;
				bad += (main_tick !== pre);
				mc += main_tick;
				for (i = 0; i < 6; i++) gc[i] += gated_ticks[i];
			end
			chk("main", 0, bad);
			chk("core", 1, nd == 0 ? gc[0] == 0 :
				gc[0] * nd + nd + 2 >= mc && gc[0] * nd <= mc + nd + 2);
			for (i = 1; i < 6; i++)
				chk("gate", g[i] ? gc[0] : 0, gc[i]);
		end
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		for (i = 0; i < 5; i++)
			bus(0, adr[i], 0, rst[i], 2'h0);
		chk("rst_main", 0, main_src_active);
		chk("rst_pll", 0, pll_src_active);
		give_verdict();
	end
endmodule : main_clock_select_gate_tb_top
bind mcs_top mcs_checker i_chk
(
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.src_ticks(src_ticks),
	.pll_src_active(pll_src_active),
	.main_src_active(main_src_active),
	.main_tick(main_tick),
	.gated_ticks(gated_ticks)
);
`default_nettype wire
